/* File: include/fifo_core_regs.svh */
// register offsets, field positions, reset values and counts for the dual fifo core
`ifndef FIFO_CORE_REGS_SVH
`define FIFO_CORE_REGS_SVH
// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define OFS_FIFO        12'h000
`define OFS_IRQ_CTRL    12'h004
`define OFS_LOCAL_GEN   12'h008
`define OFS_BUSMASTER   12'h00C
`define OFS_RD_ADDR     12'h010
`define OFS_WR_ADDR     12'h014
`define OFS_RD_COUNT    12'h018
`define OFS_WR_COUNT    12'h01C
// ----------------------------------------
// irq_ctrl_stat_reg fields
// ----------------------------------------
`define IC_SWAP_LO      24
`define IC_ADV_P2L_LO   26
`define IC_ADV_L2P_LO   28
`define IC_ORDER_LO     30
`define IC_RESET        32'h0000_0000
// ----------------------------------------
// local_general_ctrl_reg and busmaster_ctrl_reg fields
// ----------------------------------------
`define ST_P2L_EMPTY    0
`define ST_P2L_FULL     1
`define ST_L2P_EMPTY    2
`define ST_L2P_FULL     3
`define CTL_RD_EN       8
`define CTL_WR_EN       9
`define CTL_P2L_CLR     10
`define CTL_L2P_CLR     11
`define CTL_CNT_OFF     28
`define CTL_RESET       32'h0000_0000
// ----------------------------------------
// nonvolatile configuration bit and fifo size
// ----------------------------------------
`define NV_LOCAL_MODE_BIT 7
`define FIFO_DEPTH      8
`endif

/* File: include/fifo_core_pkg.sv */
// types for the dual fifo core
package fifo_core_pkg;
    typedef enum logic [1:0] {SWAP_NONE = 2'h0, SWAP_16 = 2'h1, SWAP_32 = 2'h2, SWAP_64 = 2'h3}
        swap_mode_t;
    typedef enum logic [2:0] {BUS_IDLE = 3'h1, BUS_SETUP = 3'h2, BUS_ACCESS = 3'h4} bus_state_t;
endpackage

/* File: rtl/pci_local_dual_fifo_core.sv */
// dual eight-entry fifo core between the pci and local interfaces
//
// Functional notes
// - two independent eight-word 32-bit fifos
// - one offset: read inbound, write outbound
// - advance lane selectable per side
// - default lane 0 advances on its enable
// - lane 2 setting: advance on upper write
// - endian control applies both directions
// - swap before store; lane judged swapped
// - 64-bit order bits toggle each word
// - p2l empty and l2p full always driven
// - p2l full, l2p empty only local serial mode
// - fifo flags readable in two registers
// - pop and push strobes pass two sync stages
// - clear inputs reset pointers and flags
// - master enable pins in local serial mode
// - pci mode: enables, clears as register bits
// - address and count programmed per transfer
// - completion interrupt to pci or local
// - nv bit zero: dma registers local only
// - byte-wide boot memory forbids local mode
// - local mode runs until count zero
// - no nv memory: pci-initiated default
// - request bus only enabled and count nonzero, or count ignored in local mode
`timescale 1ns/100ps
`include "fifo_core_regs.svh"
module pci_local_dual_fifo_core
    import fifo_core_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave, pci side register access
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // local direct fifo strobes and data
    input  wire logic        p2l_pop_n,
    input  wire logic        l2p_push_n,
    input  wire logic [31:0] local_wdata,
    input  wire logic [3:0]  local_be_n,
    output logic      [31:0] local_rdata,
    // local status pins
    output logic             p2l_empty_out,
    output logic             l2p_full_out,
    output logic             p2l_full_out,
    output logic             l2p_empty_out,
    // shared-pin controls
    input  wire logic        p2l_clear_n,
    input  wire logic        l2p_clear_n,
    input  wire logic        local_rd_master_en,
    input  wire logic        local_wr_master_en,
    // configuration straps and dma hooks
    input  wire logic        nv_present,
    input  wire logic        nv_byte_wide,
    input  wire logic [7:0]  nv_cfg_45,
    input  wire logic        rd_done,
    input  wire logic        wr_done,
    output logic             rd_request,
    output logic             wr_request,
    output logic             pci_irq_out,
    output logic             local_irq_out,
    output logic             local_mode_out
);
    initial
    begin
        if (DEPTH != 8)
            $error("fifo depth must be 8");
    end

    localparam int AW = 3;

    typedef struct packed {
        logic [AW:0]  p2l_wp, p2l_rp, l2p_wp, l2p_rp;
        logic [31:0]  irq_ctrl, gen_ctrl, rd_addr, wr_addr, rd_cnt, wr_cnt;
        logic [31:0]  prdata, lrdata;
        logic         pready, pslverr, pci_irq, loc_irq, local_mode, strap_done;
        logic [1:0]   pop_s, push_s, pclr_s, lclr_s, ren_s, wen_s;
        logic         pop_prev, push_prev;
    } state_t;

    state_t s_q, s_d;
    logic [31:0] p2l_mem [DEPTH];
    logic [31:0] l2p_mem [DEPTH];

    // ----------------------------------------
    // lane swapping and advance detection
    // ----------------------------------------
    function automatic logic [31:0] swap_data(input logic [31:0] d, input logic [1:0] m);
        case (m)
            SWAP_16: swap_data = {d[23:16], d[31:24], d[7:0], d[15:8]};
            SWAP_32, SWAP_64: swap_data = {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: swap_data = d;
        endcase
    endfunction

    function automatic logic [3:0] swap_be(input logic [3:0] b, input logic [1:0] m);
        case (m)
            SWAP_16: swap_be = {b[2], b[3], b[0], b[1]};
            SWAP_32, SWAP_64: swap_be = {b[0], b[1], b[2], b[3]};
            default: swap_be = b;
        endcase
    endfunction

    // lane setting 00 lane0, 01 lane1, 10 lane2, 11 lane3
    function automatic logic lane_hit(input logic [3:0] be, input logic [1:0] lane);
        lane_hit = be[lane];
    endfunction

    // ----------------------------------------
    // derived status
    // ----------------------------------------
    logic p2l_empty, p2l_full, l2p_empty, l2p_full, cnt_off;
    logic [1:0] swap_m, adv_p, adv_l;
    logic pin_mode;
    always_comb
    begin
        p2l_empty = s_q.p2l_wp == s_q.p2l_rp;
        p2l_full  = s_q.p2l_wp == {~s_q.p2l_rp[AW], s_q.p2l_rp[AW-1:0]};
        l2p_empty = s_q.l2p_wp == s_q.l2p_rp;
        l2p_full  = s_q.l2p_wp == {~s_q.l2p_rp[AW], s_q.l2p_rp[AW-1:0]};
        swap_m    = s_q.irq_ctrl[`IC_SWAP_LO +: 2];
        adv_p     = s_q.irq_ctrl[`IC_ADV_P2L_LO +: 2];
        adv_l     = s_q.irq_ctrl[`IC_ADV_L2P_LO +: 2];
        pin_mode  = s_q.local_mode;
        cnt_off   = s_q.gen_ctrl[`CTL_CNT_OFF];
    end

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic acc, wr, rd, dma_ok, mapped;
    logic [3:0] sbe, lsbe;
    logic [31:0] st_bits;
    always_comb
    begin
        acc     = psel && penable && !s_q.pready;
        wr      = acc && pwrite;
        rd      = acc && !pwrite;
        // dma registers belong to one side only; pci side blocked in local mode
        dma_ok  = !s_q.local_mode;
        mapped  = (paddr <= `OFS_WR_COUNT) && (paddr[1:0] == 2'h0);
        sbe     = swap_be(pstrb, swap_m);
        lsbe    = swap_be(~local_be_n, swap_m);
        st_bits = 32'h0;
        st_bits[`ST_P2L_EMPTY] = p2l_empty;
        st_bits[`ST_P2L_FULL]  = p2l_full;
        st_bits[`ST_L2P_EMPTY] = l2p_empty;
        st_bits[`ST_L2P_FULL]  = l2p_full;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic pop_ev, push_ev, pci_push, pci_pop, p2l_clr, l2p_clr, ren, wen;
    always_comb
    begin
        s_d = s_q;
        s_d.pop_s   = {s_q.pop_s[0], ~p2l_pop_n};
        s_d.push_s  = {s_q.push_s[0], ~l2p_push_n};
        s_d.pclr_s  = {s_q.pclr_s[0], ~p2l_clear_n};
        s_d.lclr_s  = {s_q.lclr_s[0], ~l2p_clear_n};
        s_d.ren_s   = {s_q.ren_s[0], local_rd_master_en};
        s_d.wen_s   = {s_q.wen_s[0], local_wr_master_en};
        s_d.pop_prev  = s_q.pop_s[1];
        s_d.push_prev = s_q.push_s[1];
        pop_ev  = s_q.pop_s[1] && !s_q.pop_prev;
        push_ev = s_q.push_s[1] && !s_q.push_prev && lane_hit(lsbe, adv_l);
        // pin functions in local serial mode, register bits otherwise
        p2l_clr = pin_mode ? s_q.pclr_s[1] : s_q.gen_ctrl[`CTL_P2L_CLR];
        l2p_clr = pin_mode ? s_q.lclr_s[1] : s_q.gen_ctrl[`CTL_L2P_CLR];
        ren     = pin_mode ? s_q.ren_s[1] : s_q.gen_ctrl[`CTL_RD_EN];
        wen     = pin_mode ? s_q.wen_s[1] : s_q.gen_ctrl[`CTL_WR_EN];
        pci_push = wr && paddr == `OFS_FIFO && lane_hit(sbe, adv_p);
        pci_pop  = rd && paddr == `OFS_FIFO;
        // strap capture after reset release
        if (!s_q.strap_done)
        begin
            s_d.strap_done = 1'b1;
            s_d.local_mode = nv_present && !nv_byte_wide
                && !nv_cfg_45[`NV_LOCAL_MODE_BIT];
        end
        s_d.pready  = acc;
        s_d.pslverr = acc && !mapped;
        if (rd)
        begin
            case (paddr)
                `OFS_FIFO:      s_d.prdata = l2p_empty ? 32'h0 : l2p_mem[s_q.l2p_rp[AW-1:0]];
                `OFS_IRQ_CTRL:  s_d.prdata = s_q.irq_ctrl;
                `OFS_LOCAL_GEN: s_d.prdata = (s_q.gen_ctrl & ~32'h0000_000F) | st_bits;
                `OFS_BUSMASTER: s_d.prdata = (s_q.gen_ctrl & ~32'h0000_000F) | st_bits;
                `OFS_RD_ADDR:   s_d.prdata = dma_ok ? s_q.rd_addr : 32'h0;
                `OFS_WR_ADDR:   s_d.prdata = dma_ok ? s_q.wr_addr : 32'h0;
                `OFS_RD_COUNT:  s_d.prdata = dma_ok ? s_q.rd_cnt : 32'h0;
                `OFS_WR_COUNT:  s_d.prdata = dma_ok ? s_q.wr_cnt : 32'h0;
                default:        s_d.prdata = 32'h0;
            endcase
        end
        if (wr)
        begin
            case (paddr)
                `OFS_IRQ_CTRL:  s_d.irq_ctrl = pwdata;
                `OFS_LOCAL_GEN: s_d.gen_ctrl = pwdata;
                `OFS_BUSMASTER: s_d.gen_ctrl = pwdata;
                `OFS_RD_ADDR:   if (dma_ok) s_d.rd_addr = pwdata;
                `OFS_WR_ADDR:   if (dma_ok) s_d.wr_addr = pwdata;
                `OFS_RD_COUNT:  if (dma_ok) s_d.rd_cnt = pwdata;
                `OFS_WR_COUNT:  if (dma_ok) s_d.wr_cnt = pwdata;
                default:        ;
            endcase
        end
        // pci pushes into p2l; local pops from p2l
        if (pci_push && !p2l_full)
            s_d.p2l_wp = s_q.p2l_wp + 1'b1;
        if (pop_ev && !p2l_empty)
        begin
            s_d.p2l_rp = s_q.p2l_rp + 1'b1;
            s_d.lrdata = p2l_mem[s_q.p2l_rp[AW-1:0]];
        end
        if (push_ev && !l2p_full)
            s_d.l2p_wp = s_q.l2p_wp + 1'b1;
        if (pci_pop && !l2p_empty)
            s_d.l2p_rp = s_q.l2p_rp + 1'b1;
        // 64-bit order bits toggle per word moved
        if (swap_m == SWAP_64 && ((pci_push && !p2l_full) || (push_ev && !l2p_full)))
            s_d.irq_ctrl[`IC_ORDER_LO] = ~s_d.irq_ctrl[`IC_ORDER_LO];
        if (swap_m == SWAP_64 && ((pop_ev && !p2l_empty) || (pci_pop && !l2p_empty)))
            s_d.irq_ctrl[`IC_ORDER_LO + 1] = ~s_d.irq_ctrl[`IC_ORDER_LO + 1];
        if (p2l_clr)
        begin
            s_d.p2l_wp = '0;
            s_d.p2l_rp = '0;
        end
        if (l2p_clr)
        begin
            s_d.l2p_wp = '0;
            s_d.l2p_rp = '0;
        end
        // dma byte counts, four bytes per completed word
        if (rd_done && s_q.rd_cnt != 32'h0)
            s_d.rd_cnt = (s_q.rd_cnt < 32'h4) ? 32'h0 : s_q.rd_cnt - 32'h4;
        if (wr_done && s_q.wr_cnt != 32'h0)
            s_d.wr_cnt = (s_q.wr_cnt < 32'h4) ? 32'h0 : s_q.wr_cnt - 32'h4;
        // completion interrupt routed by mode; set wins over clear
        if ((rd_done && s_q.rd_cnt <= 32'h4 && s_q.rd_cnt != 32'h0)
            || (wr_done && s_q.wr_cnt <= 32'h4 && s_q.wr_cnt != 32'h0))
        begin
            if (s_q.local_mode && !cnt_off)
                s_d.loc_irq = 1'b1;
            else if (!s_q.local_mode)
                s_d.pci_irq = 1'b1;
        end
        else if (wr && paddr == `OFS_IRQ_CTRL)
        begin
            s_d.pci_irq = 1'b0;
            s_d.loc_irq = 1'b0;
        end
    end

    // ----------------------------------------
    // storage and registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (pci_push && !p2l_full)
            p2l_mem[s_q.p2l_wp[AW-1:0]] <= swap_data(pwdata, swap_m);
        if (push_ev && !l2p_full)
            l2p_mem[s_q.l2p_wp[AW-1:0]] <= swap_data(local_wdata, swap_m);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.irq_ctrl <= `IC_RESET;
            s_q.gen_ctrl <= `CTL_RESET;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb
    begin
        prdata        = s_q.prdata;
        pready        = s_q.pready;
        pslverr       = s_q.pslverr;
        local_rdata   = s_q.lrdata;
        p2l_empty_out = p2l_empty;
        l2p_full_out  = l2p_full;
        p2l_full_out  = pin_mode && p2l_full;
        l2p_empty_out = pin_mode && l2p_empty;
        // local mode: stop at zero count unless count is ignored
        rd_request    = ren && (!p2l_full)
            && (s_q.local_mode && cnt_off || s_q.rd_cnt != 32'h0);
        wr_request    = wen && (!l2p_empty)
            && (s_q.local_mode && cnt_off || s_q.wr_cnt != 32'h0);
        pci_irq_out   = s_q.pci_irq;
        local_irq_out = s_q.loc_irq;
        local_mode_out = s_q.local_mode;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence push_full_s;
        pci_push && p2l_full;
    endsequence

    full_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_full_s |=> $stable(s_q.p2l_wp) || s_q.p2l_wp == '0)
        else $error("push into full fifo moved pointer");
    empty_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
        pop_ev && p2l_empty |=> $stable(s_q.p2l_rp) || s_q.p2l_rp == '0)
        else $error("pop from empty fifo moved pointer");
    lane_adv_a: assert property (@(posedge clk) disable iff (!rst_n)
        pci_push && !p2l_full && !p2l_clr |=> s_q.p2l_wp == $past(s_q.p2l_wp) + 1'b1)
        else $error("write pointer did not advance");
    no_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == `OFS_FIFO && !lane_hit(sbe, adv_p) && !p2l_clr |=> $stable(s_q.p2l_wp))
        else $error("pointer moved without advance lane");
    status_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.local_mode |-> !p2l_full_out && !l2p_empty_out)
        else $error("shared status pins active in pci mode");
    clear_ptr_a: assert property (@(posedge clk) disable iff (!rst_n)
        p2l_clr |=> s_q.p2l_wp == '0 && s_q.p2l_rp == '0)
        else $error("clear did not reset pointers");
    req_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.local_mode && !cnt_off && s_q.rd_cnt == 32'h0 |-> !rd_request)
        else $error("read request with zero count");
    pci_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == `OFS_RD_COUNT && s_q.local_mode && !rd_done |=> $stable(s_q.rd_cnt))
        else $error("pci wrote local-only count");
    apb_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
endmodule

/* File: test/local_side_model.sv */
// local bus side model that drives the direct fifo strobes
`timescale 1ns/100ps
module local_side_model (
    // clock
    input  wire logic        clk,
    // direct strobes and data
    output logic             p2l_pop_n,
    output logic             l2p_push_n,
    output logic      [31:0] local_wdata,
    output logic      [3:0]  local_be_n,
    // slow mode stretches every strobe phase
    input  wire logic        slow
);
    initial
    begin
        p2l_pop_n   = 1'b1;
        l2p_push_n  = 1'b1;
        local_wdata = 32'h0000_0000;
        local_be_n  = 4'hF;
    end
    // strobe low then high, each phase three clocks or more
    task automatic strobe(input bit push);
        int n;
        n = slow ? 7 : 3;
        @(posedge clk);
        if (push)
            l2p_push_n <= 1'b0;
        else
            p2l_pop_n <= 1'b0;
        repeat (n) @(posedge clk);
        l2p_push_n <= 1'b1;
        p2l_pop_n  <= 1'b1;
        repeat (n) @(posedge clk);
    endtask
    task automatic push(input logic [31:0] d, input logic [3:0] be_n);
        @(posedge clk);
        local_wdata <= d;
        local_be_n  <= be_n;
        strobe(1'b1);
        // hold time is over: show the inverse so stale data cannot pass
        local_wdata <= ~d;
        local_be_n  <= 4'hF;
    endtask
endmodule

/* File: test/tb.sv */
// self-checking testbench for the dual fifo core
`timescale 1ns/100ps
`include "fifo_core_regs.svh"
module tb;
    logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, local_rdata, local_wdata, r, q[9];
    logic [3:0] pstrb = 4'hF, local_be_n;
    logic pready, pslverr, p2l_pop_n, l2p_push_n, e;
    logic p2l_empty_out, l2p_full_out, p2l_full_out, l2p_empty_out;
    logic p2l_clear_n = 1'b1, l2p_clear_n = 1'b1, rd_en = 1'b0, wr_en = 1'b0;
    logic nv_present = 1'b0, nv_byte_wide = 1'b0, rd_done = 1'b0, wr_done = 1'b0;
    logic [7:0] nv_cfg_45 = 8'h80;
    logic rd_request, wr_request, pci_irq_out, local_irq_out, local_mode_out;
    int errors = 0, n_compared = 0, i, m;
    always #20 clk = ~clk;
    pci_local_dual_fifo_core dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .p2l_pop_n(p2l_pop_n), .l2p_push_n(l2p_push_n),
        .local_wdata(local_wdata), .local_be_n(local_be_n), .local_rdata(local_rdata),
        .p2l_empty_out(p2l_empty_out), .l2p_full_out(l2p_full_out),
        .p2l_full_out(p2l_full_out), .l2p_empty_out(l2p_empty_out),
        .p2l_clear_n(p2l_clear_n), .l2p_clear_n(l2p_clear_n), .local_rd_master_en(rd_en),
        .local_wr_master_en(wr_en), .nv_present(nv_present), .nv_byte_wide(nv_byte_wide),
        .nv_cfg_45(nv_cfg_45), .rd_done(rd_done), .wr_done(wr_done),
        .rd_request(rd_request), .wr_request(wr_request), .pci_irq_out(pci_irq_out),
        .local_irq_out(local_irq_out), .local_mode_out(local_mode_out));
    local_side_model m_u (.clk(clk), .p2l_pop_n(p2l_pop_n), .l2p_push_n(l2p_push_n),
        .local_wdata(local_wdata), .local_be_n(local_be_n), .slow(slow));
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
        begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s, r, e);
    endtask
    task automatic do_reset(input logic pres, input logic bw, input logic b7);
        @(posedge clk);
        rst_n        <= 1'b0;
        nv_present   <= pres;
        nv_byte_wide <= bw;
        nv_cfg_45    <= {b7, 7'h15};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [31:0] sw(input logic [31:0] d, input int m);
        case (m)
            1: return {d[23:16], d[31:24], d[7:0], d[15:8]};
            2: return {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: return d;
        endcase
    endfunction
    initial
    begin
        i = $urandom(32'h9C96814F);
        do_reset(1'b0, 1'b0, 1'b1);
        chk("p2l empty pin", 32'h1, 32'(p2l_empty_out));
        chk("l2p empty pin", 32'h0, 32'(l2p_empty_out));
        chk("mode", 32'h0, 32'(local_mode_out));
        // lane 0 absent: no advance, then fill past full
        wr(`OFS_FIFO, $urandom, 4'hE);
        chk("p2l empty pin", 32'h1, 32'(p2l_empty_out));
        for (i = 0; i < 9; i++)
        begin
            q[i] = $urandom;
            wr(`OFS_FIFO, q[i], 4'hF);
        end
        apb(1'b0, `OFS_BUSMASTER, 0, 4'hF, r, e);
        chk("bm status", 32'h6, r & 32'hF);
        chk("p2l full pin", 32'h0, 32'(p2l_full_out));
        for (i = 0; i < 8; i++)
        begin
            m_u.strobe(1'b0);
            chk("popped word", q[i], local_rdata);
        end
        chk("p2l empty pin", 32'h1, 32'(p2l_empty_out));
        m_u.strobe(1'b0);
        chk("empty pop", q[7], local_rdata);
        // local pushes past full, stalling now and then
        for (i = 0; i < 9; i++)
        begin
            slow <= i[0];
            q[i] = $urandom;
            m_u.push(q[i], 4'h0);
        end
        chk("l2p full pin", 32'h1, 32'(l2p_full_out));
        apb(1'b0, `OFS_LOCAL_GEN, 0, 4'hF, r, e);
        chk("gen status", 32'h9, r & 32'hF);
        for (i = 0; i < 9; i++)
        begin
            apb(1'b0, `OFS_FIFO, 0, 4'hF, r, e);
            chk("pci read", i < 8 ? q[i] : 32'h0, r);
        end
        // 16-bit local bus: advance on the upper half only
        wr(`OFS_IRQ_CTRL, 32'h2000_0000, 4'hF);
        m_u.push(32'h0000_5A5A, 4'hC);
        apb(1'b0, `OFS_LOCAL_GEN, 0, 4'hF, r, e);
        chk("l2p empty bit", 32'h4, r & 32'h4);
        q[0] = $urandom;
        m_u.push(q[0], 4'h3);
        apb(1'b0, `OFS_FIFO, 0, 4'hF, r, e);
        chk("upper half", 32'(q[0][31:16]), 32'(r[31:16]));
        // swap modes in both directions
        for (m = 0; m < 3; m++)
        begin
            wr(`OFS_IRQ_CTRL, 32'(m) << `IC_SWAP_LO, 4'hF);
            q[0] = $urandom;
            wr(`OFS_FIFO, q[0], 4'hF);
            m_u.strobe(1'b0);
            chk("swapped pop", sw(q[0], m), local_rdata);
            m_u.push(q[0], 4'h0);
            apb(1'b0, `OFS_FIFO, 0, 4'hF, r, e);
            chk("swapped read", sw(q[0], m), r);
        end
        wr(`OFS_FIFO, q[0], 4'h8);
        chk("p2l empty pin", 32'h0, 32'(p2l_empty_out));
        m_u.strobe(1'b0);
        chk("swapped byte", 32'(q[0][31:24]), 32'(local_rdata[7:0]));
        wr(`OFS_IRQ_CTRL, 32'h0300_0000, 4'hF);
        wr(`OFS_FIFO, $urandom, 4'hF);
        apb(1'b0, `OFS_IRQ_CTRL, 0, 4'hF, r, e);
        chk("order after fill", 32'h1, 32'(r[31:30]));
        m_u.strobe(1'b0);
        apb(1'b0, `OFS_IRQ_CTRL, 0, 4'hF, r, e);
        chk("order after drain", 32'h3, 32'(r[31:30]));
        // pci-initiated transfer of eight bytes
        wr(`OFS_RD_COUNT, 32'h8, 4'hF);
        wr(`OFS_BUSMASTER, 32'h100, 4'hF);
        chk("rd request", 32'h1, 32'(rd_request));
        repeat (2)
        begin
            rd_done <= 1'b1;
            @(posedge clk);
            rd_done <= 1'b0;
            @(posedge clk);
        end
        @(posedge clk);
        chk("rd request done", 32'h0, 32'(rd_request));
        chk("pci irq", 32'h1, 32'(pci_irq_out));
        chk("local irq", 32'h0, 32'(local_irq_out));
        wr(`OFS_IRQ_CTRL, 32'h0, 4'hF);
        chk("pci irq clear", 32'h0, 32'(pci_irq_out));
        // pci-initiated write transfer of one word
        wr(`OFS_WR_COUNT, 32'h4, 4'hF);
        m_u.push($urandom, 4'h0);
        wr(`OFS_BUSMASTER, 32'h200, 4'hF);
        chk("wr request", 32'h1, 32'(wr_request));
        wr_done <= 1'b1;
        @(posedge clk);
        wr_done <= 1'b0;
        @(posedge clk);
        chk("wr request done", 32'h0, 32'(wr_request));
        wr(`OFS_FIFO, $urandom, 4'hF);
        wr(`OFS_LOCAL_GEN, 32'h400, 4'hF);
        wr(`OFS_LOCAL_GEN, 32'h0, 4'hF);
        chk("reg clear", 32'h1, 32'(p2l_empty_out));
        apb(1'b0, 12'h020, 0, 4'hF, r, e);
        chk("unmapped err", 32'h1, 32'(e));
        // strap table: byte-wide boot memory, nv bit set, then local mode
        do_reset(1'b1, 1'b1, 1'b0);
        chk("mode byte-wide", 32'h0, 32'(local_mode_out));
        do_reset(1'b1, 1'b0, 1'b1);
        chk("mode nv bit set", 32'h0, 32'(local_mode_out));
        do_reset(1'b1, 1'b0, 1'b0);
        chk("mode local", 32'h1, 32'(local_mode_out));
        chk("l2p empty pin", 32'h1, 32'(l2p_empty_out));
        wr(`OFS_RD_COUNT, 32'h10, 4'hF);
        apb(1'b0, `OFS_RD_COUNT, 0, 4'hF, r, e);
        chk("count hidden", 32'h0, r);
        rd_en <= 1'b1;
        repeat (4) @(posedge clk);
        chk("rd request zero", 32'h0, 32'(rd_request));
        wr(`OFS_LOCAL_GEN, 32'h1000_0000, 4'hF);
        chk("rd request no count", 32'h1, 32'(rd_request));
        wr(`OFS_FIFO, $urandom, 4'hF);
        chk("p2l empty pin", 32'h0, 32'(p2l_empty_out));
        p2l_clear_n <= 1'b0;
        repeat (4) @(posedge clk);
        p2l_clear_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("pin clear", 32'h1, 32'(p2l_empty_out));
        end_of_test();
    end
endmodule
